// *** ssb_defines.svh ***
// Constants for the servo stop and brake control block.
// Assumes inclusion by bare name from the package and design files.
`ifndef SSB_DEFINES_SVH
`define SSB_DEFINES_SVH
// ----------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------
`define SSB_IDX_PRIMARY      8'h04
`define SSB_IDX_SECOND       8'h05
`define SSB_IDX_OT_DETECT    8'h06
`define SSB_IDX_OT_STOP      8'h07
`define SSB_IDX_LOCK_DLY     8'h08
`define SSB_IDX_BK_DLY       8'h09
`define SSB_IDX_REL_SPD      8'h10
`define SSB_IDX_STATUS       8'h20
`define SSB_IDX_MASK         8'h21
`define SSB_IDX_ACTIVE       8'h22
// ----------------------------------------------------------------------
// Ranges and reset values
// ----------------------------------------------------------------------
`define SSB_PRIMARY_MAX      16'h0002
`define SSB_SECOND_MAX       16'h0001
`define SSB_OT_DETECT_MAX    16'h0001
`define SSB_OT_STOP_MAX      16'h0002
`define SSB_LOCK_DLY_MAX     16'h0032
`define SSB_BK_DLY_MIN       16'h000a
`define SSB_BK_DLY_MAX       16'h0064
`define SSB_BK_DLY_RST       16'h0032
`define SSB_REL_SPD_MAX      16'h2710
`define SSB_REL_SPD_RST      16'h0064
// ----------------------------------------------------------------------
// Timing: 10 ms step at a 10 ns clock period
// ----------------------------------------------------------------------
`define SSB_STEP_MS          10
`define SSB_CLK_NS           10
`define SSB_STEP_CYC         ((`SSB_STEP_MS * 1000000) / `SSB_CLK_NS)
// Status bit positions
`define SSB_EV_STOP          0
`define SSB_EV_OT_WARN       1
`define SSB_EV_BK_OFF        2
`define SSB_EV_BAD_WR        3
`define SSB_NEV              4
`endif

// *** ssb_pkg.sv ***
// Types shared by the servo stop and brake control files.
// Assumes ssb_defines.svh is on the include path.
`include "ssb_defines.svh"
package ssb_pkg;
	// Motor drive action driven toward the power stage
	typedef enum logic [2:0] {
		SSB_ACT_RUN   = 3'h0,
		SSB_ACT_DB    = 3'h1,
		SSB_ACT_COAST = 3'h2,
		SSB_ACT_ZERO  = 3'h3,
		SSB_ACT_TLIM  = 3'h4,
		SSB_ACT_LOCK  = 3'h5
	} ssb_act_t;
endpackage : ssb_pkg

// *** ssb_cfg_mem.sv ***
// Small register memory holding the seven parameter words.
// Assumes writes are pre-checked by the caller; read data registered.
`timescale 1ns/10ps
`include "ssb_defines.svh"
module ssb_cfg_mem #(
	parameter int W = 16
) (
	input  wire logic         mclk_in,
	input  wire logic         rst_n_in,
	input  wire logic         we_in,
	input  wire logic [2:0]   waddr_in,
	input  wire logic [W-1:0] wdata_in,
	input  wire logic [2:0]   raddr_in,
	output logic      [W-1:0] rdata_out,
	output logic      [W-1:0] word0_out,
	output logic      [W-1:0] word1_out,
	output logic      [W-1:0] word2_out,
	output logic      [W-1:0] word3_out,
	output logic      [W-1:0] word4_out,
	output logic      [W-1:0] word5_out,
	output logic      [W-1:0] word6_out
);
	logic [W-1:0] sel_mem [0:3];
	logic [W-1:0] tim_mem [0:2];
	logic [1:0]   wt;
	logic [1:0]   rt;
	assign wt = 2'(waddr_in - 3'h4);
	assign rt = 2'(raddr_in - 3'h4);
	// Selection slots 0..3 carry no reset: like a non-volatile store they
	// survive the power cycle (reset) that makes them take effect
	always_ff @(posedge mclk_in) begin
		if (we_in && waddr_in < 3'h4) begin
			sel_mem[waddr_in[1:0]] <= wdata_in;
		end
	end
	// Timing slots 4..6 return to their defaults on reset
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tim_mem[0] <= '0;
			tim_mem[1] <= `SSB_BK_DLY_RST;
			tim_mem[2] <= `SSB_REL_SPD_RST;
			rdata_out  <= '0;
		end else begin
			if (we_in && waddr_in >= 3'h4 && waddr_in < 3'h7) begin
				tim_mem[wt] <= wdata_in;
			end
			if (raddr_in < 3'h4) begin
				rdata_out <= sel_mem[raddr_in[1:0]];
			end else if (raddr_in < 3'h7) begin
				rdata_out <= tim_mem[rt];
			end else begin
				rdata_out <= '0;
			end
		end
	end
	// Words feed logic directly; timing writes act at once
	assign word0_out = sel_mem[0];
	assign word1_out = sel_mem[1];
	assign word2_out = sel_mem[2];
	assign word3_out = sel_mem[3];
	assign word4_out = tim_mem[0];
	assign word5_out = tim_mem[1];
	assign word6_out = tim_mem[2];
endmodule : ssb_cfg_mem

// *** ssb_ctrl.sv ***
// Servo stop method selection and holding brake timing.
// Assumes same-clock register port; pins are synchronised here.
// Function
// R1: Servo-off or first alarm: dynamic brake hold, brake then release, or coast.
// R2: Second alarm: zero speed rapid stop, or reuse the primary method.
// R3: Overtravel warnings detected and reported only when detection option is one.
// R4: Overtravel stop selection zero uses the primary stop method.
// R5: Selection one: torque-limited deceleration, then locked when stopped.
// R6: Selection two: torque-limited deceleration, then free running when stopped.
// R7: Stationary servo-off: keep power for lock delay, 10 ms steps, up to 50.
// R8: Rotating stop: release brake output after 10 to 100 steps of 10 ms.
// R9: Brake output drops at delay expiry or speed below release threshold.
// R10: Stop selections apply after power cycle; brake timing applies at once.
// R11: Controller starts and stops via commands, not repeated power toggling.
// R12: Out-of-range parameter writes are ignored and keep the old value.
`timescale 1ns/10ps
`include "ssb_defines.svh"
module ssb_ctrl
	import ssb_pkg::*;
#(
	parameter int STEP_CYC = `SSB_STEP_CYC
) (
	input  wire logic               mclk_in,
	input  wire logic               rstn_in,
	input  wire logic [7:0]         addr_in,
	input  wire logic [15:0]        wdata_in,
	input  wire logic               wr_in,
	input  wire logic               rd_in,
	output logic      [15:0]        rdata_out,
	input  wire logic               servo_on_in,
	input  wire logic               alarm1_in,
	input  wire logic               alarm2_in,
	input  wire logic               main_off_in,
	input  wire logic               overtravel_in,
	input  wire logic [15:0]        speed_in,
	output ssb_pkg::ssb_act_t       act_out,
	output logic                    dynamic_brake_out,
	output logic                    motor_power_out,
	output logic                    holding_brake_output_out,
	output logic                    ot_warn_out,
	output logic                    irq_out
);
	import ssb_pkg::*;

	// ------------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------------
	logic [1:0] rst_sync;
	logic       rst_n;
	// Two stages on release keep the reset edge away from the clock
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	logic [4:0] pin_s1;
	logic [4:0] pin_s2;
	// Only the second stage is read by logic; reset to the running idle
	// level so no false servo-off stop follows every reset
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 5'h01;
			pin_s2 <= 5'h01;
		end else begin
			pin_s1 <= {overtravel_in, main_off_in, alarm2_in, alarm1_in,
				servo_on_in};
			pin_s2 <= pin_s1;
		end
	end
	logic son, al1, al2, moff, ot;
	assign son  = pin_s2[0];
	assign al1  = pin_s2[1];
	assign al2  = pin_s2[2];
	assign moff = pin_s2[3];
	assign ot   = pin_s2[4];

	// ------------------------------------------------------------------
	// Parameter store
	// ------------------------------------------------------------------
	logic [2:0]  mem_waddr;
	logic [2:0]  mem_raddr;
	logic        in_range;
	logic        pwr_wr;
	logic [15:0] mem_rdata;
	logic [15:0] lock_dly, bk_dly, rel_spd;
	logic [15:0] sel0, sel1, sel2, sel3;

	// Map indexes onto slots 0..6; anything else lands on slot 7
	function automatic logic [2:0] slot(input logic [7:0] a);
		case (a)
			`SSB_IDX_PRIMARY:   slot = 3'h0;
			`SSB_IDX_SECOND:    slot = 3'h1;
			`SSB_IDX_OT_DETECT: slot = 3'h2;
			`SSB_IDX_OT_STOP:   slot = 3'h3;
			`SSB_IDX_LOCK_DLY:  slot = 3'h4;
			`SSB_IDX_BK_DLY:    slot = 3'h5;
			`SSB_IDX_REL_SPD:   slot = 3'h6;
			default:            slot = 3'h7;
		endcase
	endfunction : slot

	assign mem_waddr = slot(addr_in);
	assign mem_raddr = slot(addr_in);
	// Range check per slot
	always_comb begin
		case (mem_waddr)
			3'h0: in_range = wdata_in <= `SSB_PRIMARY_MAX; // [R12]
			3'h1: in_range = wdata_in <= `SSB_SECOND_MAX;
			3'h2: in_range = wdata_in <= `SSB_OT_DETECT_MAX;
			3'h3: in_range = wdata_in <= `SSB_OT_STOP_MAX;
			3'h4: in_range = wdata_in <= `SSB_LOCK_DLY_MAX;
			3'h5: in_range = wdata_in >= `SSB_BK_DLY_MIN &&
				wdata_in <= `SSB_BK_DLY_MAX;
			3'h6: in_range = wdata_in <= `SSB_REL_SPD_MAX;
			default: in_range = 1'b0;
		endcase
	end
	assign pwr_wr = wr_in && (mem_waddr != 3'h7) && in_range; // [R12]

	ssb_cfg_mem #(.W(16)) u_mem (
		.mclk_in   (mclk_in),
		.rst_n_in  (rst_n),
		.we_in     (pwr_wr),
		.waddr_in  (mem_waddr),
		.wdata_in  (wdata_in),
		.raddr_in  (mem_raddr),
		.rdata_out (mem_rdata),
		.word0_out (sel0),
		.word1_out (sel1),
		.word2_out (sel2),
		.word3_out (sel3),
		.word4_out (lock_dly),
		.word5_out (bk_dly),
		.word6_out (rel_spd)
	);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_RUN  = 5'h01,
		ST_STOP = 5'h02,
		ST_LOCK = 5'h04,
		ST_BKWT = 5'h08,
		ST_OFF  = 5'h10
	} ssb_st_t;

	typedef struct packed {
		ssb_st_t     st;
		logic        latched;
		logic [1:0]  prim;
		logic        sec;
		logic        otdet;
		logic [1:0]  otstop;
		logic [31:0] cnt;
		logic [15:0] steps;
		ssb_act_t    act;
		logic        db;
		logic        pwr;
		logic        bk;
		logic        otw;
		logic [`SSB_NEV-1:0] stat;
		logic [`SSB_NEV-1:0] mask;
		logic        rd_q;
		logic [7:0]  rd_addr;
		logic        irq;
	} ssb_state_t;

	ssb_state_t s, next_s;
	logic stopped;
	logic stop_req;
	logic [`SSB_NEV-1:0] ev;
	logic [`SSB_NEV-1:0] wclr;

	assign stopped  = (speed_in == 16'h0000);
	assign stop_req = !son || al1 || al2 || moff || (ot && s.otdet);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		next_s = s;
		ev     = '0;
		wclr   = '0;
		// Selections are captured once after reset, a power-cycle stand-in
		if (!s.latched) begin
			next_s.latched = 1'b1; // [R10]
			next_s.prim    = sel0[1:0];
			next_s.sec     = sel1[0];
			next_s.otdet   = sel2[0];
			next_s.otstop  = sel3[1:0];
		end
		// Mask and clear writes
		if (wr_in && addr_in == `SSB_IDX_MASK) begin
			next_s.mask = wdata_in[`SSB_NEV-1:0];
		end
		if (wr_in && addr_in == `SSB_IDX_STATUS) begin
			wclr = wdata_in[`SSB_NEV-1:0];
		end
		if (wr_in && !pwr_wr && addr_in != `SSB_IDX_MASK &&
			addr_in != `SSB_IDX_STATUS) begin
			ev[`SSB_EV_BAD_WR] = 1'b1;
		end
		next_s.otw = ot && s.otdet; // [R3]
		if (ot && s.otdet && !s.otw) begin
			ev[`SSB_EV_OT_WARN] = 1'b1; // [R3]
		end
		next_s.cnt = (s.cnt == 32'(STEP_CYC - 1)) ? 32'h0 : s.cnt + 32'h1;
		if (s.cnt == 32'(STEP_CYC - 1) && s.steps != 16'h0) begin
			next_s.steps = s.steps - 16'h1;
		end
		case (s.st)
			ST_RUN: begin
				next_s.act = SSB_ACT_RUN;
				next_s.db  = 1'b0;
				next_s.pwr = 1'b1;
				next_s.bk  = 1'b1;
				if (stop_req) begin
					ev[`SSB_EV_STOP] = 1'b1;
					next_s.cnt = 32'h0;
					if (stopped && !son) begin
						next_s.st    = ST_LOCK;
						next_s.bk    = 1'b0;
						next_s.steps = lock_dly; // [R7]
					end else begin
						next_s.st    = ST_STOP;
						next_s.steps = bk_dly; // [R8]
					end
				end
			end
			ST_LOCK: begin
				// Power held while the brake engages, avoids axis sag
				next_s.bk = 1'b0;
				if (s.steps == 16'h0) begin
					next_s.pwr = 1'b0; // [R7]
					next_s.st  = ST_OFF;
				end
			end
			ST_STOP: begin
				next_s.st = ST_BKWT;
			end
			ST_BKWT: begin
				// Either condition drops the brake output
				if (s.bk && (s.steps == 16'h0 || speed_in < rel_spd)) begin
					next_s.bk = 1'b0; // [R8] [R9]
					ev[`SSB_EV_BK_OFF] = 1'b1;
				end
				if (!stop_req && stopped) begin
					next_s.st = ST_RUN;
				end
			end
			ST_OFF: begin
				next_s.pwr = 1'b0;
				next_s.bk  = 1'b0;
				if (!stop_req) begin
					next_s.st = ST_RUN;
				end
			end
			default: next_s.st = ST_RUN;
		endcase
		// Stop action is chosen again every cycle, so it takes its
		// after-stop form (release, lock, free run) once the shaft halts
		if (s.st == ST_STOP || s.st == ST_BKWT) begin
			if (al2 && !s.sec) begin
				next_s.act = SSB_ACT_ZERO; // [R2]
			end else if (ot && s.otdet && !al1 && !al2 && son &&
				s.otstop != 2'h0) begin
				next_s.act = stopped ?
					((s.otstop == 2'h1) ? SSB_ACT_LOCK : SSB_ACT_COAST)
					: SSB_ACT_TLIM; // [R5] [R6]
			end else begin
				// Primary method, also for overtravel selection zero
				case (s.prim) // [R1] [R4]
					2'h0: next_s.act = SSB_ACT_DB;
					2'h1: next_s.act = stopped ? SSB_ACT_COAST
						: SSB_ACT_DB;
					default: next_s.act = SSB_ACT_COAST;
				endcase
			end
			next_s.db  = (next_s.act == SSB_ACT_DB);
			next_s.pwr = (next_s.act == SSB_ACT_ZERO) ||
				(next_s.act == SSB_ACT_TLIM) ||
				(next_s.act == SSB_ACT_LOCK);
		end
		// Set wins over clear; a set mask bit hides its status bit from irq, not from reads
		next_s.stat = (s.stat & ~wclr) | ev;
		next_s.irq  = |(next_s.stat & ~next_s.mask);
		next_s.rd_q = rd_in;
		next_s.rd_addr = addr_in;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{st: ST_RUN, act: SSB_ACT_RUN, default: '0};
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------------
	// Read data: one cycle after the strobe, only then
	// ------------------------------------------------------------------
	always_comb begin
		rdata_out = 16'h0;
		if (s.rd_q) begin
			case (s.rd_addr)
				`SSB_IDX_STATUS: rdata_out = {12'h0, s.stat};
				`SSB_IDX_MASK:   rdata_out = {12'h0, s.mask};
				`SSB_IDX_ACTIVE: rdata_out = {8'h0, s.st, s.act};
				default:         rdata_out = mem_rdata;
			endcase
		end
	end

	assign act_out                  = s.act;
	assign dynamic_brake_out        = s.db;
	assign motor_power_out          = s.pwr;
	assign holding_brake_output_out = s.bk;
	assign ot_warn_out              = s.otw;
	assign irq_out                  = s.irq;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_bad_write_kept;
		@(posedge mclk_in) disable iff (!rst_n)
		(wr_in && mem_waddr == 3'h5 && !in_range) |=> (bk_dly == $past(bk_dly));
	endproperty
	a_bad_write_kept: assert property (p_bad_write_kept) // [R12]
		else $error("Out-of-range write changed brake delay");

	property p_ot_off;
		@(posedge mclk_in) disable iff (!rst_n)
		!s.otdet |=> !ot_warn_out;
	endproperty
	a_ot_off: assert property (p_ot_off) // [R3]
		else $error("Overtravel warning raised while detection off");

	property p_lock_power;
		@(posedge mclk_in) disable iff (!rst_n)
		(s.st == ST_LOCK && s.steps != 16'h0) |=> motor_power_out;
	endproperty
	a_lock_power: assert property (p_lock_power) // [R7]
		else $error("Power removed before lock delay");

	property p_bk_speed;
		@(posedge mclk_in) disable iff (!rst_n)
		(s.st == ST_BKWT && speed_in < rel_spd) |=> !holding_brake_output_out;
	endproperty
	a_bk_speed: assert property (p_bk_speed) // [R9]
		else $error("Brake output held below release speed");

	property p_bk_delay;
		@(posedge mclk_in) disable iff (!rst_n)
		(s.st == ST_BKWT && s.steps == 16'h0) |=> !holding_brake_output_out;
	endproperty
	a_bk_delay: assert property (p_bk_delay) // [R8]
		else $error("Brake output held after delay");

	property p_zero_stop;
		@(posedge mclk_in) disable iff (!rst_n)
		(s.st == ST_STOP && al2 && !s.sec) |=> (act_out == SSB_ACT_ZERO);
	endproperty
	a_zero_stop: assert property (p_zero_stop) // [R2]
		else $error("Second alarm did not zero speed");

	property p_db_hold;
		@(posedge mclk_in) disable iff (!rst_n)
		(s.st == ST_STOP && s.prim == 2'h0 && !al2 && !(ot && s.otdet))
		|=> dynamic_brake_out;
	endproperty
	a_db_hold: assert property (p_db_hold) // [R1]
		else $error("Primary method zero without dynamic brake");

	property p_irq;
		@(posedge mclk_in) disable iff (!rst_n)
		|(s.stat & ~s.mask) |-> irq_out;
	endproperty
	a_irq: assert property (p_irq)
		else $error("Interrupt low with unmasked status");

endmodule : ssb_ctrl

// *** ssb_motor_model.sv ***
// Behavioural servo motor following the drive action and motor power.
// Assumes the block's clock and its action and motor power outputs.
`timescale 1ns/10ps
module ssb_motor_model
	import ssb_pkg::*;
(
	input  wire logic              mclk_in,
	input  wire logic [15:0]       cmd_in,
	input  wire ssb_pkg::ssb_act_t act_in,
	input  wire logic              motor_power_in,
	output logic      [15:0]       speed_out
);
	initial speed_out = 16'h0000;
	// ------------------------------------------------------------------
	// Shaft speed
	// ------------------------------------------------------------------
	// Powered and running: follow the speed command; the controller
	// starts and stops the shaft by command only, never by power toggling
	// Otherwise the shaft slows one rpm a cycle, so a rotating stop
	// stays rotating long enough to exercise the brake timing
	always @(posedge mclk_in) begin
		if (motor_power_in && act_in == SSB_ACT_RUN) begin
			speed_out <= cmd_in;
		end else if (speed_out != 16'h0000) begin
			speed_out <= speed_out - 16'h0001;
		end
	end
endmodule : ssb_motor_model

// *** ssb_ctrl_tb.sv ***
// Self-checking bench for the stop and brake controller.
// Assumes a short brake step through STEP_CYC and the motor model.
`timescale 1ns/10ps
`include "ssb_defines.svh"
module ssb_ctrl_tb;
	import ssb_pkg::*;
	localparam int STEP = 10; // Cycles per 10 ms step, shortened
	logic mclk_in, rstn_in, wr_in, rd_in;
	logic [7:0] addr_in;
	logic [15:0] wdata_in, rdata_out, speed_in, cmd, v;
	logic servo_on_in, alarm1_in, alarm2_in, main_off_in, overtravel_in;
	ssb_act_t act_out;
	logic db_out, pwr_out, bk_out, ot_warn_out, irq_out;
	int n_mismatch, samples_checked, i;
	logic [7:0] idx [7] = '{`SSB_IDX_PRIMARY, `SSB_IDX_SECOND,
		`SSB_IDX_OT_DETECT, `SSB_IDX_OT_STOP, `SSB_IDX_LOCK_DLY,
		`SSB_IDX_BK_DLY, `SSB_IDX_REL_SPD};
	logic [15:0] rv [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0032, 16'h0064};

	ssb_ctrl #(.STEP_CYC(STEP)) dut (
		.mclk_in(mclk_in), .rstn_in(rstn_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .servo_on_in(servo_on_in),
		.alarm1_in(alarm1_in), .alarm2_in(alarm2_in),
		.main_off_in(main_off_in), .overtravel_in(overtravel_in),
		.speed_in(speed_in), .act_out(act_out),
		.dynamic_brake_out(db_out), .motor_power_out(pwr_out),
		.holding_brake_output_out(bk_out), .ot_warn_out(ot_warn_out),
		.irq_out(irq_out));

	ssb_motor_model motor (
		.mclk_in(mclk_in), .cmd_in(cmd), .act_in(act_out),
		.motor_power_in(pwr_out), .speed_out(speed_in));

	// ------------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------------
	initial mclk_in = 1'b0;
	always #5 mclk_in = ~mclk_in;
	// Whole run is about 3750 cycles; a hang is cut well beyond that
	initial begin
		repeat (40000) @(posedge mclk_in);
		n_mismatch++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		results();
	end

	// ------------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------------
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk_in);
	endtask : wait_cyc
	// Write: one strobe cycle, then one idle edge before any next request
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask : wr
	// Read: data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask : rd
	task automatic chk(input logic [15:0] got, exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(d, e, "register read");
	endtask : rdchk
	// Power cycle with the inputs back at a running, healthy state
	task automatic do_reset;
		servo_on_in <= 1'b1;
		alarm2_in <= 1'b0;
		overtravel_in <= 1'b0;
		rstn_in <= 1'b0;
		wait_cyc(10);
		rstn_in <= 1'b1;
		wait_cyc(4);
	endtask : do_reset
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	initial begin
		n_mismatch = 0;
		samples_checked = 0;
		{rstn_in, wr_in, rd_in, alarm1_in, alarm2_in} = '0;
		{main_off_in, overtravel_in} = '0;
		servo_on_in = 1'b1;
		addr_in = 8'h00;
		wdata_in = 16'h0000;
		cmd = 16'h0000;
		do_reset();
		// Selection words have no reset: load them once, as at install
		for (i = 0; i < 4; i++) begin
			wr(idx[i], 16'h0000);
		end
		// Reset values of the parameter words
		for (i = 0; i < 7; i++) begin
			rdchk(idx[i], rv[i]);
		end
		$display("done: reset values");
		// Refused writes, status flag and interrupt
		wr(`SSB_IDX_MASK, 16'h0000);
		wr(`SSB_IDX_STATUS, 16'h000f);
		rdchk(`SSB_IDX_STATUS, 16'h0000);
		wr(8'h30, 16'h0001);
		rdchk(`SSB_IDX_STATUS, 16'h0008);
		chk({15'h0, irq_out}, 16'h0001, "irq raised");
		wr(`SSB_IDX_MASK, 16'h000f);
		wait_cyc(2);
		chk({15'h0, irq_out}, 16'h0000, "irq masked");
		wr(`SSB_IDX_MASK, 16'h0000);
		wr(`SSB_IDX_STATUS, 16'h0008);
		wait_cyc(2);
		chk({15'h0, irq_out}, 16'h0000, "irq cleared");
		wr(`SSB_IDX_BK_DLY, 16'h0009);
		rdchk(`SSB_IDX_BK_DLY, 16'h0032);
		wr(`SSB_IDX_BK_DLY, 16'h0065);
		rdchk(`SSB_IDX_BK_DLY, 16'h0032);
		wr(`SSB_IDX_PRIMARY, 16'h0003);
		rdchk(`SSB_IDX_PRIMARY, 16'h0000);
		wr(`SSB_IDX_LOCK_DLY, 16'h0033);
		rdchk(`SSB_IDX_LOCK_DLY, 16'h0000);
		wr(`SSB_IDX_REL_SPD, 16'h2711);
		rdchk(`SSB_IDX_REL_SPD, 16'h0064);
		wr(`SSB_IDX_REL_SPD, 16'h2710);
		rdchk(`SSB_IDX_REL_SPD, 16'h2710);
		rdchk(`SSB_IDX_STATUS, 16'h0008);
		$display("done: refused writes and interrupt");
		// Overtravel while detection is off: no warning, no stop
		do_reset();
		overtravel_in <= 1'b1;
		wait_cyc(20);
		chk({15'h0, ot_warn_out}, 16'h0000, "ot warning");
		chk({13'h0, act_out}, {13'h0, SSB_ACT_RUN}, "ot action");
		// Second-type alarm with selection 0: zero speed rapid stop
		do_reset();
		alarm2_in <= 1'b1;
		wait_cyc(10);
		chk({13'h0, act_out}, {13'h0, SSB_ACT_ZERO}, "alarm2");
		$display("done: overtravel and second alarm");
		// Rotating servo-off: delay of 10 steps, speed never below 0
		do_reset();
		cmd <= 16'd3000;
		wr(`SSB_IDX_BK_DLY, 16'h000a);
		wr(`SSB_IDX_REL_SPD, 16'h0000);
		wait_cyc(5);
		servo_on_in <= 1'b0;
		wait_cyc(10);
		chk({13'h0, act_out}, {13'h0, SSB_ACT_DB}, "stop action");
		chk({15'h0, db_out}, 16'h0001, "dynamic brake");
		wait_cyc(10 * STEP - 30);
		chk({15'h0, bk_out}, 16'h0001, "brake early");
		wait_cyc(40);
		chk({15'h0, bk_out}, 16'h0000, "brake late");
		rd(`SSB_IDX_STATUS, v);
		chk(v & 16'h0004, 16'h0004, "brake-off event");
		$display("done: rotating stop by delay");
		// Rotating servo-off: long delay, speed threshold ends it first
		do_reset();
		cmd <= 16'd3000;
		wr(`SSB_IDX_BK_DLY, 16'h0064);
		wr(`SSB_IDX_REL_SPD, 16'd2950);
		wait_cyc(5);
		servo_on_in <= 1'b0;
		wait_cyc(20);
		chk({15'h0, bk_out}, 16'h0001, "brake above speed");
		wait_cyc(130);
		chk({15'h0, bk_out}, 16'h0000, "brake below speed");
		$display("done: rotating stop by speed");
		// Stationary servo-off: power held for 5 steps after brake off
		do_reset();
		cmd <= 16'h0000;
		wr(`SSB_IDX_LOCK_DLY, 16'h0005);
		wait_cyc(5);
		servo_on_in <= 1'b0;
		for (i = 0; i < 40 && bk_out !== 1'b0; i++) begin
			wait_cyc(1);
		end
		chk({15'h0, bk_out}, 16'h0000, "brake off");
		wait_cyc(5 * STEP - 10);
		chk({15'h0, pwr_out}, 16'h0001, "power held");
		wait_cyc(20);
		chk({15'h0, pwr_out}, 16'h0000, "power removed");
		$display("done: stationary lock delay");
		// Overtravel with detection on, applied by a power cycle
		wr(`SSB_IDX_OT_DETECT, 16'h0001);
		wr(`SSB_IDX_OT_STOP, 16'h0001);
		do_reset();
		cmd <= 16'd3000;
		wait_cyc(5);
		overtravel_in <= 1'b1;
		wait_cyc(10);
		chk({15'h0, ot_warn_out}, 16'h0001, "ot warning on");
		chk({13'h0, act_out}, {13'h0, SSB_ACT_TLIM}, "ot decel");
		wait_cyc(3020);
		chk({13'h0, act_out}, {13'h0, SSB_ACT_LOCK}, "ot locked");
		wr(`SSB_IDX_OT_STOP, 16'h0002);
		wait_cyc(5);
		chk({13'h0, act_out}, {13'h0, SSB_ACT_LOCK}, "not yet");
		do_reset();
		cmd <= 16'd100;
		wait_cyc(5);
		overtravel_in <= 1'b1;
		wait_cyc(10);
		chk({13'h0, act_out}, {13'h0, SSB_ACT_TLIM}, "ot decel 2");
		wait_cyc(120);
		chk({13'h0, act_out}, {13'h0, SSB_ACT_COAST}, "ot free");
		$display("done: overtravel stop selections");
		results();
	end
endmodule : ssb_ctrl_tb
